// >>> design/dac_ctrl_pkg.sv
// Purpose: Shared constants for the eight-channel DAC serial control block.
// Assumes: 24-bit frames, MSB first, 4-bit command, 4-bit address, 16-bit data.
// Notes: Command codes and field positions live here only.
package dac_ctrl_pkg;
   localparam int FRAME_BITS = 24;
   localparam int CHANNELS = 8;
   localparam int DATA_BITS = 16;
   localparam int CMD_HI = 23;
   localparam int CMD_LO = 20;
   localparam int ADDR_HI = 19;
   localparam int ADDR_LO = 16;
   localparam int CNT_W = 6;
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WRITE_IN = 4'h1;
   localparam logic [3:0] CMD_UPDATE = 4'h2;
   localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
   localparam logic [3:0] CMD_POWER = 4'h4;
   localparam logic [3:0] CMD_MASK = 4'h5;
   localparam logic [3:0] CMD_CHAIN = 4'h8;
   localparam logic [3:0] CMD_READBACK = 4'h9;
   localparam logic [3:0] CMD_WRITE_ALL = 4'ha;
   localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'hb;
   localparam logic [1:0] PWR_NORMAL = 2'h0;
   localparam logic [1:0] PWR_GND_1K = 2'h1;
   localparam logic [1:0] PWR_TRISTATE = 2'h3;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [15:0] POWER_RESET = 16'h0000;
endpackage : dac_ctrl_pkg

// >>> design/dac_reg_bank.sv
// Purpose: Input and DAC register banks, one word per channel, registered read.
// Assumes: Load strobes are one-cycle pulses on the system clock.
// Notes: Channel-wise load from input bank is a bit vector so several copy at once.
`timescale 1ns/100ps
`default_nettype none
module dac_reg_bank
   import dac_ctrl_pkg::*;
#(
   parameter int WIDTH = DATA_BITS,
   parameter int DEPTH = CHANNELS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [DEPTH-1:0] inWrite,
   input wire logic [DEPTH-1:0] dacWrite,
   input wire logic [DEPTH-1:0] dacCopy,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [$clog2(DEPTH)-1:0] rdSel,
   output logic [WIDTH-1:0] rdData,
   output logic [DEPTH*WIDTH-1:0] dacFlat
);
   logic [WIDTH-1:0] inReg_q [DEPTH];
   initial begin
      if (DEPTH < 2 || WIDTH < 1) $error("dac_reg_bank: bad size");
   end
   for (genvar i = 0; i < DEPTH; i++) begin : g_ch
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            inReg_q[i] <= DATA_RESET;
         end else if (inWrite[i]) begin
            inReg_q[i] <= wrData;
         end
      end
      // Direct write beats a copy in the same cycle; they never coincide anyway
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            dacFlat[i*WIDTH +: WIDTH] <= DATA_RESET;
         end else if (dacWrite[i]) begin
            dacFlat[i*WIDTH +: WIDTH] <= wrData;
         end else if (dacCopy[i]) begin
            dacFlat[i*WIDTH +: WIDTH] <= inReg_q[i];
         end
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdData <= DATA_RESET;
      end else begin
         rdData <= inReg_q[rdSel];
      end
   end
endmodule : dac_reg_bank
`default_nettype wire

// >>> design/octal_dac_serial_control.sv
// Purpose: Serial front end and register control of an eight-channel DAC.
// Assumes: serial clock, frame sync, data and load pin are asynchronous pins.
// Notes: Pins are oversampled at 200 MHz; the serial clock must be much slower.
// Operation
// - While frame sync low, keep shifting; bits past 24th appear on serial_out.
// - serial_out changes on rising serial clock edge.
// - Frames of odd clock counts still execute.
// - Frame sync rise latches the frame and stops shifting until next fall.
// - Readback 1001 selects one input register by address, ignores other bits.
// - Readback enables serial_out for its transfer even outside chain mode.
// - Next frame shifts out selected register: 4 undefined bits, then 16 data.
// - With frame sync high serial_out only weakly holds the last bit.
// - Command 0100 loads two power bits per channel from low 16 bits.
// - Power pair 00 normal, 01 one kilohm to ground, 11 three-state.
// - Power-down leaves DAC registers alone; updates still apply.
// - load_dac_n low: 0001 updates input and DAC register at frame end.
// - load_dac_n high: 0001 only input; later load fall copies to DAC.
// - Command 0101 loads eight-bit load mask from bits 7..0, reset zero.
// - Masked channels ignore load_dac_n falls; 0001 and 1010 still see its low level.
// - Command 0010 copies selected input registers to DAC registers.
// - Command 0011 writes input and DAC register of addressed channel.
// - Each load_dac_n fall while frame sync is high copies input to DAC on unmasked channels.
// - load_dac_n tied low makes the mask irrelevant.
// - Chain setting bit 0 enables chain mode; reset is standalone.
// - Frame is 24 bits MSB first: command, address, data.
// - serial_in sampled into shift register on serial clock falling edge.
`timescale 1ns/100ps
`default_nettype none
module octal_dac_serial_control
   import dac_ctrl_pkg::*;
#(
   parameter int NCH = CHANNELS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic serialClock,
   input wire logic frameSyncN,
   input wire logic serialIn,
   input wire logic loadDacN,
   output logic serialOut,
   output logic serialOutEn,
   output logic serialOutKeep,
   output logic chainEnable,
   output logic [2*NCH-1:0] powerMode,
   output logic [NCH-1:0] loadPinMask,
   output logic [NCH*DATA_BITS-1:0] dacValue
);
   initial begin
      if (NCH != CHANNELS) $error("octal_dac_serial_control: NCH must be 8");
   end

   logic rst1_q, rstSync_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst1_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rst1_q <= 1'b1;
         rstSync_q <= rst1_q;
      end
   end

   // Three-stage pin synchronisers; stage 1 feeds only stage 2
   logic [3:0] pin1_q, pin2_q, pin3_q;
   always_ff @(posedge clock or negedge rstSync_q) begin
      if (!rstSync_q) begin
         pin1_q <= 4'hf;
         pin2_q <= 4'hf;
         pin3_q <= 4'hf;
      end else begin
         pin1_q <= {loadDacN, serialIn, frameSyncN, serialClock};
         pin2_q <= pin1_q;
         pin3_q <= pin2_q;
      end
   end
   // A change counts once stages two and three agree
   logic [3:0] pinLvl_q;
   always_ff @(posedge clock or negedge rstSync_q) begin
      if (!rstSync_q) begin
         pinLvl_q <= 4'hf;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (pin2_q[b] == pin3_q[b]) pinLvl_q[b] <= pin3_q[b];
         end
      end
   end
   logic [3:0] pinAgree;
   logic sclkRise, sclkFall, fsFall, fsRise, ldFall, fsLow, ldLow, sdiLvl;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         pinAgree[b] = (pin2_q[b] == pin3_q[b]) ? pin3_q[b] : pinLvl_q[b];
      end
   end
   assign sclkRise = pinAgree[0] && !pinLvl_q[0];
   assign sclkFall = !pinAgree[0] && pinLvl_q[0];
   assign fsFall = !pinAgree[1] && pinLvl_q[1];
   assign fsRise = pinAgree[1] && !pinLvl_q[1];
   assign fsLow = !pinLvl_q[1];
   assign sdiLvl = pin3_q[2];
   assign ldFall = !pinAgree[3] && pinLvl_q[3];
   assign ldLow = !pinLvl_q[3];

   // Shift register; top bit, bit 23, is the outgoing bit
   logic [FRAME_BITS-1:0] shift_q;
   logic [CNT_W-1:0] bitCnt_q;
   logic sdoBit_q;
   always_ff @(posedge clock or negedge rstSync_q) begin
      if (!rstSync_q) begin
         shift_q <= '0;
         bitCnt_q <= '0;
      end else if (fsFall) begin
         bitCnt_q <= '0;
      end else if (fsLow && sclkFall) begin
         shift_q <= {shift_q[FRAME_BITS-2:0], sdiLvl};
         if (bitCnt_q != CNT_W'(FRAME_BITS)) bitCnt_q <= bitCnt_q + 1'b1;
      end
   end

   // Readback data replaces the outgoing stream for one frame
   logic readArm_q, readActive_q;
   logic [FRAME_BITS-1:0] outShift_q;
   logic [DATA_BITS-1:0] rdData;
   always_ff @(posedge clock or negedge rstSync_q) begin
      if (!rstSync_q) begin
         sdoBit_q <= 1'b0;
         outShift_q <= '0;
      end else if (fsFall) begin
         outShift_q <= readArm_q ? {4'h0, rdData, 4'h0} : '0;
      end else if (fsLow && sclkRise) begin
         // Rising edge drives, so the partner samples on the next fall
         if (readActive_q) begin
            sdoBit_q <= outShift_q[FRAME_BITS-1];
            outShift_q <= {outShift_q[FRAME_BITS-2:0], 1'b0};
         end else begin
            sdoBit_q <= shift_q[FRAME_BITS-1];
         end
      end
   end

   // Frame execution at frame sync rise, whatever the count
   logic chain_q, execute;
   logic [3:0] cmd, addr;
   logic [DATA_BITS-1:0] data;
   logic [2*NCH-1:0] power_q;
   logic [NCH-1:0] mask_q;
   logic [2:0] rdSel_q;
   assign execute = fsRise;
   assign cmd = shift_q[CMD_HI:CMD_LO];
   assign addr = shift_q[ADDR_HI:ADDR_LO];
   assign data = shift_q[DATA_BITS-1:0];

   always_ff @(posedge clock or negedge rstSync_q) begin
      if (!rstSync_q) begin
         chain_q <= 1'b0;
         power_q <= POWER_RESET;
         mask_q <= MASK_RESET;
      end else if (execute) begin
         if (cmd == CMD_CHAIN) chain_q <= data[0];
         if (cmd == CMD_POWER) power_q <= data;
         if (cmd == CMD_MASK) mask_q <= data[NCH-1:0];
      end
   end

   always_ff @(posedge clock or negedge rstSync_q) begin
      if (!rstSync_q) begin
         readArm_q <= 1'b0;
         readActive_q <= 1'b0;
         rdSel_q <= '0;
      end else begin
         if (execute) begin
            readArm_q <= (cmd == CMD_READBACK) && !addr[3];
            if (cmd == CMD_READBACK) rdSel_q <= addr[2:0];
         end
         if (fsFall) readActive_q <= readArm_q;
         else if (fsRise) readActive_q <= 1'b0;
      end
   end

   // Channel strobes
   logic [NCH-1:0] addrHit, inWr, dacWr, dacCp, effLdFall;
   always_comb begin
      addrHit = '0;
      if (!addr[3]) addrHit[addr[2:0]] = 1'b1;
      inWr = '0;
      dacWr = '0;
      dacCp = '0;
      if (execute) begin
         unique case (cmd)
            CMD_WRITE_IN: begin
               inWr = addrHit;
               dacWr = addrHit & ~(mask_q & {NCH{1'b0}}) & {NCH{ldLow}};
            end
            CMD_UPDATE: dacCp = data[NCH-1:0];
            CMD_WRITE_UPD: begin
               inWr = addrHit;
               dacWr = addrHit;
            end
            CMD_WRITE_ALL: begin
               inWr = {NCH{1'b1}};
               dacWr = {NCH{ldLow}};
            end
            CMD_WRITE_UPD_ALL: begin
               inWr = {NCH{1'b1}};
               dacWr = {NCH{1'b1}};
            end
            default: ;
         endcase
      end
      effLdFall = {NCH{ldFall && !fsLow}} & ~mask_q;
      dacCp = dacCp | effLdFall;
   end

   dac_reg_bank #(.WIDTH(DATA_BITS), .DEPTH(NCH)) u_bank (
      .clock(clock),
      .rstn(rstSync_q),
      .inWrite(inWr),
      .dacWrite(dacWr),
      .dacCopy(dacCp),
      .wrData(data),
      .rdSel(rdSel_q),
      .rdData(rdData),
      .dacFlat(dacValue)
   );

   always_ff @(posedge clock or negedge rstSync_q) begin
      if (!rstSync_q) begin
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
         serialOutKeep <= 1'b0;
         chainEnable <= 1'b0;
         powerMode <= POWER_RESET;
         loadPinMask <= MASK_RESET;
      end else begin
         serialOut <= sdoBit_q;
         serialOutEn <= fsLow && (chain_q || readActive_q);
         serialOutKeep <= !fsLow;
         chainEnable <= chain_q;
         powerMode <= power_q;
         loadPinMask <= mask_q;
      end
   end

   AST_MASK_LOAD: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_MASK |=> mask_q == $past(data[NCH-1:0]))
      else $error("mask not loaded");
   AST_POWER_LOAD: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_POWER |-> ##2 powerMode == $past(data, 2))
      else $error("power mode not loaded");
   AST_CHAIN_BIT: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_CHAIN |-> ##2 chainEnable == $past(data[0], 2))
      else $error("chain bit wrong");
   AST_NO_SHIFT_IDLE: assert property (@(posedge clock) disable iff (!rstSync_q)
      !fsLow && !fsFall |=> $stable(shift_q))
      else $error("shift while frame idle");
   AST_SDO_RISE_ONLY: assert property (@(posedge clock) disable iff (!rstSync_q)
      !(fsLow && sclkRise) && !fsFall |=> $stable(sdoBit_q))
      else $error("serial out moved off rising edge");
   AST_KEEP_IDLE: assert property (@(posedge clock) disable iff (!rstSync_q)
      !fsLow |=> serialOutKeep && !serialOutEn)
      else $error("serial out driven while idle");
   AST_MASK_BLOCKS: assert property (@(posedge clock) disable iff (!rstSync_q)
      ldFall && !fsLow && !execute |-> (dacCp & mask_q) == '0)
      else $error("masked channel copied");
   AST_READ_EN: assert property (@(posedge clock) disable iff (!rstSync_q)
      fsFall && readArm_q |=> ##1 serialOutEn || !fsLow)
      else $error("readback did not enable serial out");

   // Strobe and data path checks against the latched frame
   AST_WRITE_PIN_LOW: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_WRITE_IN && ldLow && !addr[3] |=> dacValue[addr[2:0]*DATA_BITS +: DATA_BITS] == $past(data))
      else $error("pin low write did not reach DAC register");
   AST_WRITE_PIN_HIGH: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_WRITE_IN && !ldLow |=> $stable(dacValue))
      else $error("pin high write changed DAC register");
   AST_WRITE_UPD: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_WRITE_UPD && !addr[3] |=> dacValue[addr[2:0]*DATA_BITS +: DATA_BITS] == $past(data))
      else $error("write and update missed DAC register");
   AST_WRITE_UPD_HI: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_WRITE_UPD && addr[3] && !ldFall |=> $stable(dacValue))
      else $error("unmapped address changed a channel");
   AST_POWER_KEEPS_DAC: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_POWER |=> $stable(dacValue))
      else $error("power command changed DAC register");
   AST_READ_SEL: assert property (@(posedge clock) disable iff (!rstSync_q)
      execute && cmd == CMD_READBACK |=> rdSel_q == $past(addr[2:0]))
      else $error("readback select not taken");
   AST_READ_LOAD: assert property (@(posedge clock) disable iff (!rstSync_q)
      fsFall && readArm_q |=> outShift_q[DATA_BITS+3:4] == $past(rdData))
      else $error("readback word not loaded");
   AST_SHIFT_IN: assert property (@(posedge clock) disable iff (!rstSync_q)
      fsLow && sclkFall |=> shift_q[0] == $past(sdiLvl))
      else $error("serial in bit not taken");
   AST_PASS_OUT: assert property (@(posedge clock) disable iff (!rstSync_q)
      fsLow && sclkRise && !readActive_q |=> sdoBit_q == $past(shift_q[FRAME_BITS-1]))
      else $error("overflow bit not passed on");
   AST_CHAIN_DRIVE: assert property (@(posedge clock) disable iff (!rstSync_q)
      fsLow && chain_q |=> serialOutEn && !serialOutKeep)
      else $error("chain mode did not drive serial out");
   AST_LOAD_FALL: assert property (@(posedge clock) disable iff (!rstSync_q)
      ldFall && !fsLow |-> (dacCp & ~mask_q) == ~mask_q)
      else $error("unmasked channel not copied");
endmodule : octal_dac_serial_control
`default_nettype wire

// >>> tb/dac_host_model.sv
// Purpose: Host controller model that drives frames on the serial pins.
// Assumes: Serial clock idles low; data moves mid low phase; 125 ns period.
// Notes: The data line is driven to its inverse after each frame, while frame sync is high.
`timescale 1ns/100ps
`default_nettype none
module dac_host_model (
   output logic serialClock,
   output logic frameSyncN,
   output logic serialIn,
   input wire logic serialOut,
   input wire logic serialOutEn
);
   logic [47:0] got;
   logic enSeen;

   initial begin
      serialClock = 1'b0;
      frameSyncN = 1'b1;
      serialIn = 1'b0;
      got = '0;
      enSeen = 1'b0;
   end

   // Sends n bits MSB first, one clock each, 24 per chained device
   task automatic xfer(input logic [47:0] bits, input int n);
      got = '0;
      enSeen = 1'b0;
      frameSyncN = 1'b0;
      #62.5;
      for (int i = n - 1; i >= 0; i--) begin
         #31.25 serialIn = bits[i];
         #31.25 serialClock = 1'b1;
         // Read just before the fall, where the far side's output is valid
         #62.5 got = {got[46:0], serialOut};
         enSeen = enSeen | serialOutEn;
         serialClock = 1'b0;
      end
      // Frame rises only after the final clock of the burst
      #62.5 frameSyncN = 1'b1;
      serialIn = ~serialIn;
      #250;
   endtask : xfer
endmodule : dac_host_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the eight-channel DAC serial control.
// Assumes: Frames come from the host model; the load pin moves on clock falls.
// Notes: Register outputs are compared after the host's idle gap of 50 clocks.
`timescale 1ns/100ps
`default_nettype none
module tb
   import dac_ctrl_pkg::*;
;
   logic clock, rstn, loadDacN;
   logic serialClock, frameSyncN, serialIn;
   logic serialOut, serialOutEn, serialOutKeep, chainEnable;
   logic [2*CHANNELS-1:0] powerMode;
   logic [CHANNELS-1:0] loadPinMask;
   logic [CHANNELS*DATA_BITS-1:0] dacValue;
   int errCount;
   int comparisons;

   octal_dac_serial_control #(.NCH(CHANNELS)) i_dut (
      .clock(clock), .rstn(rstn), .serialClock(serialClock), .frameSyncN(frameSyncN),
      .serialIn(serialIn), .loadDacN(loadDacN), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .serialOutKeep(serialOutKeep), .chainEnable(chainEnable),
      .powerMode(powerMode), .loadPinMask(loadPinMask), .dacValue(dacValue)
   );

   dac_host_model host (
      .serialClock(serialClock), .frameSyncN(frameSyncN), .serialIn(serialIn),
      .serialOut(serialOut), .serialOutEn(serialOutEn)
   );

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic testDone();
      $display("comparisons %0d mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : testDone

   task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] act);
      comparisons++;
      if (act !== exp) begin
         errCount++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, act);
      end
   endtask : chk

   function automatic logic [15:0] ch(input int n);
      return dacValue[16*n +: 16];
   endfunction : ch

   task automatic send(input logic [23:0] w);
      host.xfer({24'h0, w}, FRAME_BITS);
   endtask : send

   task automatic setPin(input logic v);
      @(negedge clock) loadDacN = v;
      repeat (20) @(negedge clock);
   endtask : setPin

   initial begin
      #400000;
      errCount++;
      testDone();
   end

   initial begin
      errCount = 0;
      comparisons = 0;
      rstn = 1'b0;
      loadDacN = 1'b1;
      repeat (12) @(negedge clock);
      rstn = 1'b1;
      repeat (20) @(negedge clock);
      chk("dacValue", '0, dacValue);
      chk("loadPinMask", MASK_RESET, loadPinMask);
      chk("powerMode", POWER_RESET, powerMode);
      chk("chainEnable", 1'b0, chainEnable);
      $display("done: reset values");
      send(24'h321234);
      chk("ch2", 16'h1234, ch(2));
      send(24'h155555);
      chk("ch5 held", 16'h0, ch(5));
      setPin(1'b0);
      setPin(1'b1);
      chk("ch5 loaded", 16'h5555, ch(5));
      setPin(1'b0);
      send(24'h111111);
      chk("ch1 pin low", 16'h1111, ch(1));
      setPin(1'b1);
      $display("done: load pin");
      send(24'h5f0020);
      chk("mask", 8'h20, loadPinMask);
      send(24'h156666);
      setPin(1'b0);
      setPin(1'b1);
      chk("ch5 masked", 16'h5555, ch(5));
      send(24'h200020);
      chk("ch5 update", 16'h6666, ch(5));
      setPin(1'b0);
      send(24'h157777);
      chk("ch5 pin tied low", 16'h7777, ch(5));
      setPin(1'b1);
      $display("done: load mask");
      // Bits 18..16 set on purpose: they must not leak into any channel
      send(24'h4700c4);
      chk("powerMode", 16'h00c4, powerMode);
      send(24'h33beef);
      chk("ch3 powered down", 16'hbeef, ch(3));
      $display("done: power modes");
      send(24'h95ffff);
      chk("out enable cmd", 1'b0, host.enSeen);
      send(24'h000000);
      chk("readback", 16'h7777, host.got[19:4]);
      chk("out enable read", 1'b1, host.enSeen);
      chk("keeper", 1'b1, serialOutKeep);
      send(24'h000000);
      chk("out enable after", 1'b0, host.enSeen);
      $display("done: readback");
      host.xfer({20'h0, 28'ha36abcd}, 28);
      chk("ch6 odd count", 16'habcd, ch(6));
      send(24'h800001);
      chk("chainEnable", 1'b1, chainEnable);
      host.xfer(48'h340f0f_f00000, 2 * FRAME_BITS);
      chk("passthrough", 24'h340f0f, host.got[23:0]);
      chk("ch4 untouched", 16'h0, ch(4));
      $display("done: chain mode");
      testDone();
   end
endmodule : tb
`default_nettype wire
